// ===== verilog/pcs_switch.sv
// Notes on behaviour
// - All cams compare one shared reference signal.
// - On below off: set strictly between them.
// - On above off: set above on or below off.
// - Lead time times velocity advances both thresholds.
// - On, off and lead are eight-entry lists.
// - Fixed hysteresis stops flicker; keep thresholds apart.
// - Null selection deactivates all cam generation.
// - Only permitted identifiers are accepted as selection.
// - Cam one at bit zero, ascending.
// - Both axes selecting at phase change flags error.
// - All cams re-evaluated every position loop cycle.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_switch
   import pcs_pkg::*;
#(
   parameter int NCAM = 8
)
(
   // APB clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Position loop side, same clock domain.
   input wire logic loop_tick,
   input wire pcs_feedback_t feedback,
   // Double-axis check.
   input wire logic other_axis_sel_active,
   input wire logic config_phase_three_to_four,
   // Results.
   output logic [NCAM-1:0] cam_out,
   output logic duplicate_config_error,
   output logic irq
);

   // Permitted reference selections; anything else is refused at the bus.
   // Null is in the list because writing it is how software switches the function off.
   function automatic logic sel_permitted(input logic [7:0] id);
      sel_permitted = (id == `PCS_SEL_NULL) || (id == `PCS_SEL_POS1) || (id == `PCS_SEL_POS2);
   endfunction : sel_permitted

   // Register state.
   // The lists are plain flops indexed by cam number; eight entries cost little at this width.
   logic [7:0] sel_reg; // Selected reference identifier.
   logic [7:0] sel_next;
   pcs_cam_cfg_t cfg_reg [NCAM]; // Per-cam thresholds and lead times.
   logic [NCAM-1:0] cam_reg; // Cam status word.
   logic [NCAM-1:0] cam_next;
   logic [`PCS_IRQ_W-1:0] sts_reg; // Sticky event bits.
   logic [`PCS_IRQ_W-1:0] sts_next;
   logic [`PCS_IRQ_W-1:0] en_reg; // Interrupt enables.
   logic [`PCS_IRQ_W-1:0] en_next;
   logic err_reg; // Duplicate configuration error flag.
   logic err_next;
   logic irq_reg;
   logic pready_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // The decode is split into named wires so the flops below stay one line each.
   // Bus phase decode; a write lands on the access edge where pready is high.
   wire logic setup = psel && !penable;
   wire logic wr_acc = psel && penable && pready_reg && pwrite;
   wire logic [2:0] grp = paddr[7:5];
   wire logic [2:0] idx = paddr[4:2];
   // Only word-aligned list addresses are mapped; the low two address bits must be zero.
   wire logic in_list = (grp == `PCS_GRP_ON) || (grp == `PCS_GRP_OFF) || (grp == `PCS_GRP_LEAD);
   wire logic hit_sel = paddr == `PCS_OFF_SEL;
   wire logic hit_cam = paddr == `PCS_OFF_CAM;
   wire logic hit_sts = paddr == `PCS_OFF_IRQ_STS;
   wire logic hit_clr = paddr == `PCS_OFF_IRQ_CLR;
   wire logic hit_en = paddr == `PCS_OFF_IRQ_EN;
   wire logic hit_err = paddr == `PCS_OFF_ERR;
   wire logic mapped = hit_sel || hit_cam || hit_sts || hit_clr || hit_en || hit_err
                     || (in_list && paddr[1:0] == 2'b00);
   // A write of an identifier outside the list is dropped and reported.
   wire logic sel_wr = wr_acc && hit_sel;
   wire logic sel_ok = sel_permitted(pwdata[7:0]);
   wire logic sel_reject = sel_wr && !sel_ok;

   // Function is live only with a non-null identifier selected.
   wire logic func_active = sel_reg != `PCS_SEL_NULL;
   // A second-position selection picks that input; every other accepted value picks the first.
   // The null selection also picks the first, but func_active then masks the result.
   // One reference feeds every cam.
   wire logic signed [31:0] ref_val = (sel_reg == `PCS_SEL_POS2) ? feedback.pos2 : feedback.pos1;

   // Read mux for the list registers.
   // The lead list is sixteen bits wide, so its upper half reads as zero.
   logic [31:0] list_rd;
   always_comb
   begin
      list_rd = 32'h0000_0000;
      unique case (grp)
         `PCS_GRP_ON: list_rd = cfg_reg[idx].on_thr;
         `PCS_GRP_OFF: list_rd = cfg_reg[idx].off_thr;
         `PCS_GRP_LEAD: list_rd = {16'h0000, cfg_reg[idx].lead};
         default: list_rd = 32'h0000_0000;
      endcase
   end

   // Read data is prepared in the setup cycle so it can come from a flop.
   // The cost is a fixed one-cycle answer; the gain is a registered prdata with a short path to the pin.
   wire logic [31:0] rd_word = hit_sel ? {24'h00_0000, sel_reg}
                             : hit_cam ? {{(32-NCAM){1'b0}}, cam_reg}
                             : hit_sts ? {{(32-`PCS_IRQ_W){1'b0}}, sts_reg}
                             : hit_en ? {{(32-`PCS_IRQ_W){1'b0}}, en_reg}
                             : hit_err ? {31'h0000_0000, err_reg}
                             : in_list ? list_rd : 32'h0000_0000;

   // Per-cam comparators, cam i drives status bit i.
   // Every comparator sees the same reference and velocity and differs only in its settings and its own present cam bit.
   logic [NCAM-1:0] hits;
   genvar gi;
   generate
      for (gi = 0; gi < NCAM; gi++)
      begin : g_cam
         pcs_cam_unit u_cam (
            .pclk(pclk),
            .presetn(presetn),
            .ref_val(ref_val),
            .vel(feedback.vel),
            .cfg(cfg_reg[gi]),
            .cur_bit(cam_reg[gi]),
            .hit(hits[gi])
         );
      end
   endgenerate

   // Cam word is rebuilt on every loop tick; inactive function forces all clear.
   // Limitation: a change of selection shows in the cam word only at the next loop tick.
   assign cam_next = !loop_tick ? cam_reg
                   : func_active ? hits : {NCAM{1'b0}};

   // Selection register keeps its value when a refused identifier is written.
   assign sel_next = (sel_wr && sel_ok) ? pwdata[7:0] : sel_reg;

   // Error check at the phase three to four transition of a double-axis unit.
   wire logic dup_evt = config_phase_three_to_four && func_active && other_axis_sel_active;
   // The flag stands until the next transition strobe runs the check again.
   // The other axis reports only whether it holds a non-null selection of its own.
   assign err_next = config_phase_three_to_four ? dup_evt : err_reg;

   // Events; a set in the same cycle as a clear survives the clear.
   // The cam event fires on any change of the word, so one interrupt covers all eight cams.
   wire logic [`PCS_IRQ_W-1:0] evt;
   assign evt[`PCS_IRQ_DUP] = dup_evt;
   assign evt[`PCS_IRQ_REJ] = sel_reject;
   assign evt[`PCS_IRQ_CAM] = cam_next != cam_reg;
   wire logic [`PCS_IRQ_W-1:0] clr = (wr_acc && hit_clr) ? pwdata[`PCS_IRQ_W-1:0] : {`PCS_IRQ_W{1'b0}};
   assign sts_next = (sts_reg & ~clr) | evt;
   assign en_next = (wr_acc && hit_en) ? pwdata[`PCS_IRQ_W-1:0] : en_reg;

   // Bus handshake and read data flops.
   // A refused selection write still completes; the refusal is reported on pslverr.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         // Ready rises in the access cycle, exactly one cycle after setup.
         pready_reg <= setup;
         prdata_reg <= setup ? rd_word : prdata_reg;
         pslverr_reg <= setup && (!mapped || (pwrite && hit_sel && !sel_permitted(pwdata[7:0])));
      end
   end

   // Control and status flops.
   // The irq flop uses the next values, so it rises in the same cycle as the status bit behind it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_reg <= `PCS_SEL_NULL;
         cam_reg <= {NCAM{1'b0}};
         sts_reg <= {`PCS_IRQ_W{1'b0}};
         en_reg <= {`PCS_IRQ_W{1'b0}};
         err_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         sel_reg <= sel_next;
         cam_reg <= cam_next;
         sts_reg <= sts_next;
         en_reg <= en_next;
         err_reg <= err_next;
         irq_reg <= |(sts_next & en_next);
      end
   end

   // List registers; each entry has its own address so all eight must be written.
   // Lists reset to zero only, so an unwritten lead entry means no advance.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NCAM; i++)
         begin
            cfg_reg[i] <= '0;
         end
      end
      else if (wr_acc && in_list)
      begin
         // Entry i of each list belongs to cam i.
         unique case (grp)
            `PCS_GRP_ON: cfg_reg[idx].on_thr <= pwdata;
            `PCS_GRP_OFF: cfg_reg[idx].off_thr <= pwdata;
            `PCS_GRP_LEAD: cfg_reg[idx].lead <= pwdata[15:0];
            default: cfg_reg[idx] <= cfg_reg[idx];
         endcase
      end
   end

   // Every output comes straight from a flop.
   // Nothing combinational reaches a pin, which keeps timing at the block boundary simple.
   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign cam_out = cam_reg;
   assign duplicate_config_error = err_reg;
   assign irq = irq_reg;

   // Checks on the cam word, the selection, the error flag and the bus.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_INACTIVE_CLEAR: assert property (loop_tick && !func_active |=> cam_out == '0)
      else $error("Cam bits not cleared while inactive.");
   AST_TICK_EVAL: assert property (loop_tick && func_active |=> cam_out == $past(hits))
      else $error("Cam word not taken from comparators on tick.");
   AST_NO_TICK_HOLD: assert property (!loop_tick |=> $stable(cam_out))
      else $error("Cam word changed without a loop tick.");
   AST_SEL_REFUSED: assert property (sel_reject |=> sel_reg == $past(sel_reg) && sts_reg[`PCS_IRQ_REJ])
      else $error("Refused identifier was stored or not reported.");
   AST_SEL_ALWAYS_OK: assert property (sel_permitted(sel_reg))
      else $error("Selection holds a non-permitted identifier.");
   AST_DUP_RAISE: assert property (config_phase_three_to_four && func_active && other_axis_sel_active
                                   |=> duplicate_config_error ##0 sts_reg[`PCS_IRQ_DUP])
      else $error("Duplicate configuration not flagged.");
   AST_DUP_SINGLE: assert property (config_phase_three_to_four && !(func_active && other_axis_sel_active)
                                    |=> !duplicate_config_error)
      else $error("Error flagged with a single configuration.");
   AST_IRQ_LEVEL: assert property (irq == |(sts_reg & en_reg))
      else $error("Interrupt level disagrees with enabled status.");
   AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("Ready not one cycle after setup.");

   // A status bit that an event sets is seen set one cycle later, even against a clear.
   AST_STS_SET_WINS: assert property (|evt |=> (sts_reg & $past(evt)) == $past(evt))
      else $error("Event lost against a status clear.");
   // Status bits fall only through a clear write.
   AST_STS_HOLD: assert property (!(wr_acc && hit_clr) |=> (sts_reg & $past(sts_reg)) == $past(sts_reg))
      else $error("Status bit fell without a clear.");
   // An enable write lands as written.
   AST_EN_WRITE: assert property (wr_acc && hit_en |=> en_reg == $past(pwdata[`PCS_IRQ_W-1:0]))
      else $error("Enable write did not land.");

   // An unmapped address is answered with an error.
   AST_SLVERR_UNMAPPED: assert property (setup && !mapped |=> pslverr)
      else $error("Unmapped access not refused.");
   // The error response never comes without ready.
   AST_SLVERR_READY: assert property (pslverr |-> pready)
      else $error("Error raised outside the access cycle.");
   // Read data stands from one setup cycle to the next.
   AST_PRDATA_HOLD: assert property (!setup |=> $stable(prdata))
      else $error("Read data changed outside a setup cycle.");
   // A permitted identifier is stored as written.
   AST_SEL_ACCEPT: assert property (sel_wr && sel_ok |=> sel_reg == $past(pwdata[7:0]))
      else $error("Permitted identifier not stored.");
   // The error flag only moves at a transition strobe.
   AST_DUP_HOLD: assert property (!config_phase_three_to_four |=> $stable(duplicate_config_error))
      else $error("Error flag changed without a transition.");

   // Covers for the main scenarios and the set-against-clear corner.
   COV_CAM_ON: cover property (loop_tick && func_active ##1 cam_out != '0);
   COV_DUP: cover property (dup_evt);
   COV_REJECT: cover property (sel_reject);
   COV_IRQ: cover property ($rose(irq));
   COV_CLR_AND_SET: cover property (wr_acc && hit_clr && |evt);

endmodule : pcs_switch
`default_nettype wire

// ===== verilog/pcs_defines.svh
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// Register byte offsets on the APB bus.
`define PCS_OFF_SEL 8'h00
`define PCS_OFF_CAM 8'h04
`define PCS_OFF_IRQ_STS 8'h08
`define PCS_OFF_IRQ_CLR 8'h0C
`define PCS_OFF_IRQ_EN 8'h10
`define PCS_OFF_ERR 8'h14

// Threshold and lead-time lists: group in address bits 7:5, entry in bits 4:2.
`define PCS_GRP_ON 3'h1
`define PCS_GRP_OFF 3'h2
`define PCS_GRP_LEAD 3'h3

// Reference signal identifiers; zero is the null identifier.
`define PCS_SEL_NULL 8'h00
`define PCS_SEL_POS1 8'h01
`define PCS_SEL_POS2 8'h02

// Interrupt status bit positions.
`define PCS_IRQ_DUP 0
`define PCS_IRQ_REJ 1
`define PCS_IRQ_CAM 2
`define PCS_IRQ_W 3

// Fixed switch hysteresis in reference units.
`define PCS_HYST 32'h0000_0004

// Lead time is in position loop cycles with this many fraction bits.
`define PCS_LEAD_FRAC 8

`endif

// ===== verilog/pcs_pkg.sv
`default_nettype none
package pcs_pkg;

   // Feedback values delivered once per position loop cycle.
   typedef struct packed {
      logic signed [31:0] pos1;
      logic signed [31:0] pos2;
      logic signed [31:0] vel;
   } pcs_feedback_t;

   // Settings of one cam.
   typedef struct packed {
      logic signed [31:0] on_thr;
      logic signed [31:0] off_thr;
      logic [15:0] lead;
   } pcs_cam_cfg_t;

endpackage : pcs_pkg
`default_nettype wire

// ===== verilog/pcs_cam_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

// One cam comparator: lead-time correction, window test and hysteresis.
module pcs_cam_unit
   import pcs_pkg::*;
(
   // Clock and reset, used only by the checks below.
   input wire logic pclk,
   input wire logic presetn,
   // Evaluation inputs.
   input wire logic signed [31:0] ref_val,
   input wire logic signed [31:0] vel,
   input wire pcs_cam_cfg_t cfg,
   input wire logic cur_bit,
   // Result for the next cam bit.
   output logic hit
);

   // Correction is velocity times lead; the product is kept wide to avoid overflow.
   wire logic signed [48:0] prod = vel * $signed({1'b0, cfg.lead});
   wire logic signed [48:0] corr_w = prod >>> `PCS_LEAD_FRAC;
   wire logic signed [31:0] corr = corr_w[31:0];
   // Thresholds are pulled toward the reference so the bit switches early.
   wire logic signed [31:0] on_eff = cfg.on_thr - corr;
   wire logic signed [31:0] off_eff = cfg.off_thr - corr;
   // A set bit sees a widened band so a value jittering at an edge cannot flicker.
   wire logic signed [31:0] on_h = cur_bit ? on_eff - `PCS_HYST : on_eff;
   wire logic signed [31:0] off_h = cur_bit ? off_eff + `PCS_HYST : off_eff;
   wire logic above_on = ref_val > on_h;
   wire logic below_off = ref_val < off_h;
   wire logic normal = on_eff < off_eff;

   // Normal window needs both, inverted window either; equal thresholds give nothing.
   assign hit = normal ? (above_on && below_off)
              : (on_eff > off_eff) && (above_on || below_off);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_WINDOW_STRICT: assert property (!cur_bit && normal |-> hit == (ref_val > on_eff && ref_val < off_eff))
      else $error("Normal window result wrong.");
   AST_INVERT_STRICT: assert property (!cur_bit && on_eff > off_eff |-> hit == (ref_val > on_eff || ref_val < off_eff))
      else $error("Inverted window result wrong.");
   AST_HOLD_HYST: assert property (cur_bit && normal && ref_val > on_eff && ref_val < off_eff |-> hit)
      else $error("Set bit dropped inside its window.");
   AST_LEAD_ZERO: assert property (cfg.lead == 16'h0000 |-> on_eff == cfg.on_thr && off_eff == cfg.off_thr)
      else $error("Zero lead time moved a threshold.");

endmodule : pcs_cam_unit
`default_nettype wire

// ===== tb/pcs_fb_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the drive's position loop: a strobe every PERIOD cycles.
module pcs_fb_model
   import pcs_pkg::*;
#(
   parameter int PERIOD = 6
)
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Values the bench wants fed back.
   input wire pcs_feedback_t fb_in,
   // Loop side of the switch.
   output logic loop_tick,
   output pcs_feedback_t feedback
);
   int cnt_reg; // Cycles since the last strobe.

   // The strobe is free running, so the bench never picks a kind moment.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= 0;
         loop_tick <= 1'b0;
      end
      else
      begin
         cnt_reg <= (cnt_reg == PERIOD - 1) ? 0 : cnt_reg + 1;
         loop_tick <= (cnt_reg == PERIOD - 1);
      end
   end

   // Feedback is a level that the bench changes between strobes.
   assign feedback = fb_in;
endmodule : pcs_fb_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module testbench
   import pcs_pkg::*;
();
   // Bus, loop and phase signals.
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, loop_tick;
   logic other_act, ph_strobe, dup, irq, err;
   logic [7:0] paddr, cam_out, exp_cam, sel;
   logic [31:0] pwdata, prdata, rd;
   pcs_feedback_t fb_in, feedback;
   // Cam settings as written, kept for the expectation.
   logic signed [31:0] on_t [8];
   logic signed [31:0] off_t [8];
   logic [15:0] ld_t [8];
   int errors, num_checks;

   pcs_switch i_pcs_switch (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .loop_tick(loop_tick), .feedback(feedback),
      .other_axis_sel_active(other_act), .config_phase_three_to_four(ph_strobe),
      .cam_out(cam_out), .duplicate_config_error(dup), .irq(irq));
   pcs_fb_model i_pcs_fb_model (.pclk(pclk), .presetn(presetn), .fb_in(fb_in),
      .loop_tick(loop_tick), .feedback(feedback));

   // The 100 MHz clock.
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // Compares one value and reports a difference at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Waits for ready (sel 0) or the loop strobe (sel 1); a hang ends the run.
   task automatic wait_hi(input logic which);
      int n;
      for (n = 0; n < 40; n++)
      begin
         @(posedge pclk);
         if ((which ? loop_tick : pready) === 1'b1)
            break;
      end
      if (n == 40)
      begin
         errors++;
         complete_run();
      end
   endtask : wait_hi

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_hi(1'b0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Expected cam bit, with lead correction and hysteresis from the present bit.
   function automatic logic cam_exp(input logic signed [31:0] r, v, on, off, input logic [15:0] ld,
      input logic cur);
      logic signed [63:0] c, h, a, b;
      c = (64'(v) * $signed({48'h0000_0000_0000, ld})) >>> `PCS_LEAD_FRAC;
      h = 0;
      if (cur)
         h = `PCS_HYST;
      a = on - c - h;
      b = off - c + h;
      return (on < off) ? (r > a && r < b) : ((on > off) ? (r > a || r < b) : 1'b0);
   endfunction : cam_exp

   // Feeds one loop cycle and checks the whole cam word one cycle after the strobe.
   task automatic tick(input logic signed [31:0] p1, p2, v);
      logic [7:0] nx;
      @(posedge pclk);
      fb_in <= {p1, p2, v};
      for (int i = 0; i < 8; i++)
         nx[i] = (sel != `PCS_SEL_NULL) && cam_exp((sel == `PCS_SEL_POS2) ? p2 : p1, v, on_t[i],
            off_t[i], ld_t[i], exp_cam[i]);
      wait_hi(1'b1);
      exp_cam = nx;
      #1;
      chk(cam_out, exp_cam);
   endtask : tick

   // Pulses the phase change strobe and checks the duplicate flag.
   task automatic phase(input logic oth, input logic ex);
      @(posedge pclk);
      other_act <= oth;
      ph_strobe <= 1'b1;
      @(posedge pclk);
      ph_strobe <= 1'b0;
      #1;
      chk(dup, ex);
   endtask : phase

   // Random reference value around the threshold range.
   function automatic logic signed [31:0] rnd();
      return $signed($urandom_range(0, 2200)) - 1100;
   endfunction : rnd

   initial
   begin
      logic signed [31:0] p;
      {psel, penable, pwrite, paddr, pwdata, other_act, ph_strobe} = '0;
      fb_in = '0;
      sel = '0;
      exp_cam = '0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(23));
      // Each of the six single registers reads zero after reset, an unmapped one errors.
      for (int a = 0; a < 6; a++)
      begin
         apb(1'b0, 8'(a * 4), 0);
         chk(rd, 0);
      end
      apb(1'b0, 8'h18, 0);
      chk(err, 1);
      // An identifier outside the permitted list is refused and flagged.
      apb(1'b1, `PCS_OFF_SEL, 32'h0000_0003);
      chk(err, 1);
      apb(1'b1, `PCS_OFF_IRQ_EN, 32'h0000_0007);
      apb(1'b0, `PCS_OFF_SEL, 0);
      chk(rd, 0);
      apb(1'b0, `PCS_OFF_IRQ_STS, 0);
      chk(rd, 32'h0000_0002);
      chk(irq, 1);
      apb(1'b1, `PCS_OFF_IRQ_CLR, 32'h0000_0002);
      apb(1'b0, `PCS_OFF_IRQ_STS, 0);
      chk(rd, 0);
      chk(irq, 0);
      // All eight entries of every list are written, the lead of cam 0 as zero.
      for (int i = 0; i < 8; i++)
      begin
         on_t[i] = rnd();
         off_t[i] = (i == 2) ? on_t[i] : rnd();
         ld_t[i] = (i == 0) ? 16'h0000 : ((i == 1) ? 16'h0100 : 16'($urandom_range(0, 511)));
         apb(1'b1, {`PCS_GRP_ON, 3'(i), 2'b00}, on_t[i]);
         apb(1'b1, {`PCS_GRP_OFF, 3'(i), 2'b00}, off_t[i]);
         apb(1'b1, {`PCS_GRP_LEAD, 3'(i), 2'b00}, {16'h0000, ld_t[i]});
      end
      // Both reference signals in turn, often right at a threshold.
      for (int s = 1; s < 3; s++)
      begin
         apb(1'b1, `PCS_OFF_SEL, s);
         sel = 8'(s);
         chk(err, 0);
         // Loop ticks ran during the write; settle the word on the new selection with unchanged feedback.
         tick(fb_in.pos1, fb_in.pos2, fb_in.vel);
         for (int k = 0; k < 48; k++)
         begin
            p = (k % 3 == 0) ? on_t[k % 8] + $signed($urandom_range(0, 10)) - 5 : rnd();
            if (k % 6 == 3)
               p = off_t[k % 8] + $signed($urandom_range(0, 10)) - 5;
            tick((s == 1) ? p : rnd(), (s == 1) ? rnd() : p, $signed($urandom_range(0, 32)) - 16);
         end
      end
      apb(1'b0, `PCS_OFF_CAM, 0);
      chk(rd, {24'h00_0000, exp_cam});
      apb(1'b0, `PCS_OFF_IRQ_STS, 0);
      chk(rd, 32'h0000_0004);
      chk(irq, 1);
      apb(1'b1, `PCS_OFF_IRQ_EN, 32'h0000_0003);
      apb(1'b1, `PCS_OFF_IRQ_CLR, 32'h0000_0004);
      chk(irq, 0);
      apb(1'b0, `PCS_OFF_IRQ_STS, 0);
      chk(rd, 0);
      // The null identifier switches every cam off at the next loop cycle.
      apb(1'b1, `PCS_OFF_SEL, `PCS_SEL_NULL);
      sel = `PCS_SEL_NULL;
      tick(on_t[0], on_t[0], 0);
      // Only a selection held on both axes at the phase change is an error.
      phase(1'b1, 1'b0);
      apb(1'b1, `PCS_OFF_SEL, `PCS_SEL_POS1);
      phase(1'b0, 1'b0);
      phase(1'b1, 1'b1);
      apb(1'b0, `PCS_OFF_ERR, 0);
      chk(rd, 1);
      apb(1'b0, `PCS_OFF_IRQ_STS, 0);
      chk(rd[0], 1);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
